// *** core/wku_top.v ***
// wakeup and external interrupt unit: line flags, nmi, apb registers
// assumes apb3 master on pclk; pads and on-chip wakeups are asynchronous
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "wku_defs.vh"

module wku_top
(
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // pads and on-chip sources
    input  wire [17:0] line_pad_in,
    input  wire        nmi_pad_in,
    input  wire [1:0]  onchip_wakeup_in,
    // pad controls
    output wire [17:0] line_filter_enable,
    output wire [17:0] line_pullup_enable,
    output wire        nmi_filter_enable,
    output wire        nmi_pin_mux_lock,
    // requests to the system
    output wire [2:0]  irq_vector,
    output wire        wakeup_request,
    output wire        nmi_irq,
    output wire        critical_irq,
    output wire        machine_check_req
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    localparam [8:0] SEL_NSR  = 9'h001;
    localparam [8:0] SEL_NCR  = 9'h002;
    localparam [8:0] SEL_LINE_STATUS_REGISTER = 9'h004;
    localparam [8:0] SEL_IRQ_REQUEST_ENABLE = 9'h008;
    localparam [8:0] SEL_WAKEUP_REQUEST_ENABLE = 9'h010;
    localparam [8:0] SEL_RISE = 9'h020;
    localparam [8:0] SEL_FALL = 9'h040;
    localparam [8:0] SEL_FILT = 9'h080;
    localparam [8:0] SEL_PULL = 9'h100;

    reg  [17:0] irq_en_q;
    reg  [17:0] wk_en_q;
    reg  [17:0] rise_q;
    reg  [17:0] fall_q;
    reg  [17:0] filt_q;
    reg  [17:0] pull_q;
    reg  [17:0] flag_q;
    reg  [17:0] flag_d;

    reg         nif_q;
    reg         nif_d;
    reg         novf_q;
    reg         novf_d;
    reg         nlock_q;
    reg  [1:0]  ndss_q;
    reg         nwre_q;
    reg         nree_q;
    reg         nfee_q;
    reg         nfe_q;

    reg  [1:0]  oc_s1_q;
    reg  [1:0]  oc_s2_q;

    reg  [31:0] prdata_q;
    reg  [31:0] rdata_d;
    reg         pready_q;
    reg         pslverr_q;

    reg  [2:0]  irq_vec_q;
    reg  [2:0]  irq_vec_d;
    reg         wakeup_q;
    reg         wakeup_d;
    reg         nmi_irq_q;
    reg         crit_irq_q;
    reg         mchk_q;
    reg         nmi_pend_d;
    reg         mux_lock_q;

    wire [18:0] evt;
    wire [17:0] line_evt;
    wire        nmi_evt;
    wire [8:0]  rd_sel;
    wire [8:0]  wr_sel;
    wire        wr_en;
    wire        nmi_armed;
    wire [17:0] w1c_mask;

    ////////////////////////////////////////////////////////////////////
    // address decode, shared by setup-phase read and access-phase write

    function [8:0] reg_sel;
        input [7:0] ofs;
        begin
            case (ofs)
                `WKU_OFS_NSR:  reg_sel = SEL_NSR;
                `WKU_OFS_NCR:  reg_sel = SEL_NCR;
                `WKU_OFS_LINE_STATUS_REGISTER: reg_sel = SEL_LINE_STATUS_REGISTER;
                `WKU_OFS_IRQ_REQUEST_ENABLE: reg_sel = SEL_IRQ_REQUEST_ENABLE;
                `WKU_OFS_WAKEUP_REQUEST_ENABLE: reg_sel = SEL_WAKEUP_REQUEST_ENABLE;
                `WKU_OFS_RISE: reg_sel = SEL_RISE;
                `WKU_OFS_FALL: reg_sel = SEL_FALL;
                `WKU_OFS_FILT: reg_sel = SEL_FILT;
                `WKU_OFS_PULL: reg_sel = SEL_PULL;
                default:       reg_sel = 9'h000;
            endcase
        end
    endfunction

    assign rd_sel = reg_sel(paddr[7:0]);
    assign wr_sel = wr_en ? reg_sel(paddr[7:0]) : 9'h000;
    // write lands on the edge that sees pready high, never on an error
    assign wr_en  = psel & penable & pwrite & pready_q & ~pslverr_q;

    ////////////////////////////////////////////////////////////////////
    // synchronisers and edge detection

    wku_edge_detect u_edge
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pad_in  ({nmi_pad_in, line_pad_in}),
        .rise_en ({nree_q, rise_q}),
        .fall_en ({nfee_q, fall_q}),
        .evt     (evt)
    );

    assign line_evt = evt[17:0];
    assign nmi_evt  = evt[18];

    // on-chip wakeups come from another domain
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oc_s1_q <= 2'h0;
            oc_s2_q <= 2'h0;
        end
        else
        begin
            oc_s1_q <= onchip_wakeup_in;
            oc_s2_q <= oc_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration registers

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_en_q <= `WKU_RST_LINES;
            wk_en_q  <= `WKU_RST_LINES;
            rise_q   <= `WKU_RST_LINES;
            fall_q   <= `WKU_RST_LINES;
            filt_q   <= `WKU_RST_LINES;
            pull_q   <= `WKU_RST_LINES;
        end
        else
        begin
            if (wr_sel == SEL_IRQ_REQUEST_ENABLE)
                irq_en_q <= pwdata[17:0];
            if (wr_sel == SEL_WAKEUP_REQUEST_ENABLE)
                wk_en_q <= pwdata[17:0];
            if (wr_sel == SEL_RISE)
                rise_q <= pwdata[17:0];
            if (wr_sel == SEL_FALL)
            begin
                fall_q <= pwdata[17:0];
                // periodic line has no falling edge
                fall_q[`WKU_PERIODIC_LN] <= 1'b0;
            end
            if (wr_sel == SEL_FILT)
            begin
                filt_q <= pwdata[17:0];
                filt_q[`WKU_PERIODIC_LN] <= 1'b0;
            end
            if (wr_sel == SEL_PULL)
                pull_q <= pwdata[17:0];
        end
    end

    // nmi configuration freezes once locked until reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nlock_q <= 1'b0;
            ndss_q  <= `WKU_RST_DSS;
            nwre_q  <= 1'b0;
            nree_q  <= 1'b0;
            nfee_q  <= 1'b0;
            nfe_q   <= 1'b0;
        end
        else if ((wr_sel == SEL_NCR) && !nlock_q)
        begin
            nlock_q <= pwdata[`WKU_NCR_LOCK];
            ndss_q  <= pwdata[`WKU_NCR_DSS_HI:`WKU_NCR_DSS_LO];
            nwre_q  <= pwdata[`WKU_NCR_NWRE];
            nree_q  <= pwdata[`WKU_NCR_NREE];
            nfee_q  <= pwdata[`WKU_NCR_NFEE];
            nfe_q   <= pwdata[`WKU_NCR_NFE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status flags: a set in the clearing cycle wins

    assign w1c_mask = (wr_sel == SEL_LINE_STATUS_REGISTER) ? pwdata[17:0] : 18'h00000;

    always @*
    begin
        flag_d = (flag_q & ~w1c_mask) | line_evt;
    end

    always @*
    begin
        nif_d  = nif_q;
        novf_d = novf_q;
        if ((wr_sel == SEL_NSR) && pwdata[`WKU_NSR_NIF])
            nif_d = 1'b0;
        if ((wr_sel == SEL_NSR) && pwdata[`WKU_NSR_NOVF])
            novf_d = 1'b0;
        if (nmi_evt)
        begin
            nif_d = 1'b1;
            if (nif_q)
                novf_d = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= `WKU_RST_LINES;
            nif_q  <= 1'b0;
            novf_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
            nif_q  <= nif_d;
            novf_q <= novf_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request generation

    // both nmi edges off disables every nmi request and the pin mux lock
    assign nmi_armed = nree_q | nfee_q;

    always @*
    begin
        irq_vec_d[0] = |(flag_q[`WKU_GRP0_HI:`WKU_GRP0_LO] &
                         irq_en_q[`WKU_GRP0_HI:`WKU_GRP0_LO]);
        irq_vec_d[1] = |(flag_q[`WKU_GRP1_HI:`WKU_GRP1_LO] &
                         irq_en_q[`WKU_GRP1_HI:`WKU_GRP1_LO]);
        irq_vec_d[2] = |(flag_q[`WKU_GRP2_HI:`WKU_GRP2_LO] &
                         irq_en_q[`WKU_GRP2_HI:`WKU_GRP2_LO]);
        // overrun alone keeps the request pending
        nmi_pend_d   = nmi_armed & (nif_q | novf_q);
        wakeup_d     = (|(flag_q & wk_en_q)) |
                       (|oc_s2_q) |
                       (nwre_q & nmi_pend_d);
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_vec_q  <= 3'h0;
            wakeup_q   <= 1'b0;
            nmi_irq_q  <= 1'b0;
            crit_irq_q <= 1'b0;
            mchk_q     <= 1'b0;
            mux_lock_q <= 1'b0;
        end
        else
        begin
            irq_vec_q  <= irq_vec_d;
            wakeup_q   <= wakeup_d;
            nmi_irq_q  <= nmi_pend_d & (ndss_q == `WKU_DSS_NMI);
            crit_irq_q <= nmi_pend_d & (ndss_q == `WKU_DSS_CRIT);
            mchk_q     <= nmi_pend_d & (ndss_q == `WKU_DSS_MCHK);
            mux_lock_q <= nmi_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb response: zero wait states, data captured in setup

    always @*
    begin
        rdata_d = 32'h00000000;
        case (rd_sel)
            SEL_NSR:
            begin
                rdata_d[`WKU_NSR_NIF]  = nif_q;
                rdata_d[`WKU_NSR_NOVF] = novf_q;
            end
            SEL_NCR:
            begin
                rdata_d[`WKU_NCR_LOCK] = nlock_q;
                rdata_d[`WKU_NCR_DSS_HI:`WKU_NCR_DSS_LO] = ndss_q;
                rdata_d[`WKU_NCR_NWRE] = nwre_q;
                rdata_d[`WKU_NCR_NREE] = nree_q;
                rdata_d[`WKU_NCR_NFEE] = nfee_q;
                rdata_d[`WKU_NCR_NFE]  = nfe_q;
            end
            SEL_LINE_STATUS_REGISTER:
            begin
                rdata_d[17:0] = flag_q;
                // on-chip bits are status only, cleared at their source
                rdata_d[`WKU_LINE_STATUS_REGISTER_OC_LO+1:`WKU_LINE_STATUS_REGISTER_OC_LO] = oc_s2_q;
            end
            SEL_IRQ_REQUEST_ENABLE: rdata_d[17:0] = irq_en_q;
            SEL_WAKEUP_REQUEST_ENABLE: rdata_d[17:0] = wk_en_q;
            SEL_RISE: rdata_d[17:0] = rise_q;
            SEL_FALL: rdata_d[17:0] = fall_q;
            SEL_FILT: rdata_d[17:0] = filt_q;
            SEL_PULL: rdata_d[17:0] = pull_q;
            default:  rdata_d = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= psel & ~penable;
            pslverr_q <= psel & ~penable & (rd_sel == 9'h000);
            if (psel && !penable && !pwrite)
                prdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign line_filter_enable = filt_q;
    assign line_pullup_enable = pull_q;
    assign nmi_filter_enable  = nfe_q;
    assign nmi_pin_mux_lock   = mux_lock_q;
    assign irq_vector         = irq_vec_q;
    assign wakeup_request     = wakeup_q;
    assign nmi_irq            = nmi_irq_q;
    assign critical_irq       = crit_irq_q;
    assign machine_check_req  = mchk_q;

endmodule // wku_top

`default_nettype wire

// *** core/wku_defs.vh ***
// register offsets, field positions and reset values for the wakeup unit
// assumes a 32-bit apb slave decoding the low address byte only
`ifndef WKU_DEFS_VH
`define WKU_DEFS_VH

// line counts and vector grouping
`define WKU_LINES        18
`define WKU_ONCHIP       2
`define WKU_GRP0_LO      0
`define WKU_GRP0_HI      7
`define WKU_GRP1_LO      8
`define WKU_GRP1_HI      15
`define WKU_GRP2_LO      16
`define WKU_GRP2_HI      17
`define WKU_PERIODIC_LN  0

// register byte offsets
`define WKU_OFS_NSR      8'h00
`define WKU_OFS_NCR      8'h08
`define WKU_OFS_LINE_STATUS_REGISTER     8'h14
`define WKU_OFS_IRQ_REQUEST_ENABLE     8'h18
`define WKU_OFS_WAKEUP_REQUEST_ENABLE     8'h1C
`define WKU_OFS_RISE     8'h28
`define WKU_OFS_FALL     8'h2C
`define WKU_OFS_FILT     8'h30
`define WKU_OFS_PULL     8'h34

// nmi status field positions
`define WKU_NSR_NIF      31
`define WKU_NSR_NOVF     30

// nmi config field positions
`define WKU_NCR_LOCK     31
`define WKU_NCR_DSS_HI   30
`define WKU_NCR_DSS_LO   29
`define WKU_NCR_NWRE     28
`define WKU_NCR_NREE     26
`define WKU_NCR_NFEE     25
`define WKU_NCR_NFE      24

// status register: on-chip bits sit left of the line flags
`define WKU_LINE_STATUS_REGISTER_OC_LO   18

// destination select codes
`define WKU_DSS_NMI      2'h0
`define WKU_DSS_CRIT     2'h1
`define WKU_DSS_MCHK     2'h2
`define WKU_DSS_NONE     2'h3

// reset values
`define WKU_RST_LINES    18'h00000
`define WKU_RST_DSS      2'h0

`endif

// *** core/wku_edge_detect.v ***
// two-flop synchroniser and per-bit edge detector for the pad inputs
// assumes pad inputs are asynchronous to pclk; enables are pclk-domain
`timescale 1ns/100ps
`default_nettype none

module wku_edge_detect
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // pads and edge selection
    input  wire [18:0] pad_in,
    input  wire [18:0] rise_en,
    input  wire [18:0] fall_en,
    // one-cycle event pulses
    output wire [18:0] evt
);

    reg  [18:0] s1_q;
    reg  [18:0] s2_q;
    reg  [18:0] prev_q;
    reg  [18:0] evt_q;

    genvar i;
    generate
        for (i = 0; i < 19; i = i + 1)
        begin : g_bit
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_q[i]   <= 1'b0;
                    s2_q[i]   <= 1'b0;
                    prev_q[i] <= 1'b0;
                    evt_q[i]  <= 1'b0;
                end
                else
                begin
                    s1_q[i]   <= pad_in[i];
                    s2_q[i]   <= s1_q[i];
                    prev_q[i] <= s2_q[i];
                    // with both enables low nothing ever fires
                    evt_q[i]  <= (rise_en[i] & s2_q[i] & ~prev_q[i]) |
                                 (fall_en[i] & ~s2_q[i] & prev_q[i]);
                end
            end
        end
    endgenerate

    assign evt = evt_q;

endmodule // wku_edge_detect

`default_nettype wire

// *** sim/wku_pad_model.sv ***
// pad-side model: line pads with bench drive and the pad pullup
// assumes the bench owns drive enables and levels, pullups come from uut
`timescale 1ns/100ps
`default_nettype none

module wku_pad_model
(
    // bench drive
    input  wire logic [17:0] line_drv_en,
    input  wire logic [17:0] line_drv_val,
    // pad control from the unit
    input  wire logic [17:0] line_pullup_enable,
    // pad levels
    output wire logic [17:0] line_pad_in
);
    // a floating pad reads 1 while its pullup is on, otherwise the inverse of its drive value
    assign line_pad_in = (line_drv_en & line_drv_val)
                       | (~line_drv_en & (line_pullup_enable | ~line_drv_val));
endmodule // wku_pad_model

`default_nettype wire

// *** sim/wku_chk.sv ***
// port-level assertions for the wakeup unit
// assumes one pclk domain; bound onto every wku_top instance
`timescale 1ns/100ps
`default_nettype none

module wku_chk
(
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // sources and pad controls
    input wire logic [1:0]  onchip_wakeup_in,
    input wire logic [17:0] line_filter_enable,
    input wire logic [17:0] line_pullup_enable,
    input wire logic        nmi_filter_enable,
    input wire logic        nmi_pin_mux_lock,
    // requests
    input wire logic        wakeup_request,
    input wire logic        nmi_irq,
    input wire logic        critical_irq,
    input wire logic        machine_check_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic ncr_wr_q;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ncr_wr_q <= 1'b0;
        else
            ncr_wr_q <= psel && penable && pready && pwrite
                        && paddr[7:0] == 8'h08;

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr(logic [7:0] a);
        psel && penable && pready && pwrite && !pslverr && paddr[7:0] == a;
    endsequence

    a_access_once: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not exactly one access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pull_mirror: assert property (
        s_wr(8'h34) |=> line_pullup_enable == $past(pwdata[17:0]))
        else $error("pullup output differs from write");
    a_filt_mirror: assert property (
        s_wr(8'h30) |=> line_filter_enable == {$past(pwdata[17:1]), 1'b0})
        else $error("filter output differs from write");
    a_periodic_nofilt: assert property (!line_filter_enable[0])
        else $error("periodic line filter enabled");
    a_dest_single: assert property (
        $onehot0({nmi_irq, critical_irq, machine_check_req}))
        else $error("more than one nmi destination");
    a_onchip_wake: assert property (
        (|onchip_wakeup_in) [*6] |-> wakeup_request)
        else $error("on-chip wakeup not forwarded");
    a_nfe_cause: assert property (
        $changed(nmi_filter_enable) |-> ncr_wr_q)
        else $error("nmi filter moved without config write");
    a_mux_lock: assert property (
        $rose(nmi_pin_mux_lock) |-> $past(ncr_wr_q))
        else $error("mux lock rose without config write");
endmodule // wku_chk

bind wku_top wku_chk u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .onchip_wakeup_in(onchip_wakeup_in),
    .line_filter_enable(line_filter_enable),
    .line_pullup_enable(line_pullup_enable),
    .nmi_filter_enable(nmi_filter_enable),
    .nmi_pin_mux_lock(nmi_pin_mux_lock), .wakeup_request(wakeup_request),
    .nmi_irq(nmi_irq), .critical_irq(critical_irq),
    .machine_check_req(machine_check_req)
);

`default_nettype wire

// *** sim/wku_tb_top.sv ***
// directed apb bench for the wakeup unit with a pad model
// assumes zero-wait apb slave; line pads driven via wku_pad_model, nmi pad driven directly
`timescale 1ns/100ps
`default_nettype none

module wku_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        nmi_drv = 0, er;
    logic [31:0] paddr = 0, pwdata = 0, rd;
    logic [17:0] drv_en = 18'h3FFDF, drv = 18'h00020;
    logic [1:0]  onchip = 0;
    wire  [31:0] prdata;
    wire  [17:0] pads, filt, pull;
    wire  [2:0]  vec;
    wire         pready, pslverr, nfe, mlock, wake, nmi, crit, mchk;
    int          fail_count = 0, checked = 0, cyc = 0, i;
    logic [7:0]  ofs [9] = '{8'h00, 8'h08, 8'h14, 8'h18, 8'h1C, 8'h28,
                             8'h2C, 8'h30, 8'h34};

    always #50 pclk = ~pclk;

    wku_top uut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_pad_in(pads),
        .nmi_pad_in(nmi_drv), .onchip_wakeup_in(onchip),
        .line_filter_enable(filt), .line_pullup_enable(pull),
        .nmi_filter_enable(nfe), .nmi_pin_mux_lock(mlock),
        .irq_vector(vec), .wakeup_request(wake), .nmi_irq(nmi),
        .critical_irq(crit), .machine_check_req(mchk)
    );
    wku_pad_model u_pads
    (
        .line_drv_en(drv_en), .line_drv_val(drv),
        .line_pullup_enable(pull), .line_pad_in(pads)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(0, a, 0);
        chk({er, rd[30:0]}, {1'b0, exp[30:0]});
        chk(rd, exp);
    endtask
    task automatic pad(input logic [17:0] v);
        @(posedge pclk);
        drv <= v;
        wt(8);
    endtask
    task automatic npad(input logic v);
        @(posedge pclk);
        nmi_drv <= v;
        wt(8);
    endtask

    always @(posedge pclk)
        if (++cyc >= 20000)
        begin
            fail_count++;
            wrap_up();
        end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        wt(2);
        presetn <= 1;
        for (i = 0; i < 9; i++) rdchk(ofs[i], 0);
        xfer(0, 8'h04, 0);
        chk({er, rd[30:0]}, 32'h80000000);
        // pads first, edge enables after them, so the pullup makes no edge
        for (i = 8; i > 2; i--) xfer(1, ofs[i], 32'hFFFFFFFF);
        for (i = 3; i < 9; i++)
            rdchk(ofs[i], i == 6 || i == 7 ? 32'h3FFFE : 32'h3FFFF);
        chk({14'h0, filt}, 32'h3FFFE);
        chk({14'h0, pull}, 32'h3FFFF);
        for (i = 3; i < 9; i++) xfer(1, ofs[i], 0);
        xfer(1, 8'h14, 32'h3FFFF);
        // floating line 5 rises only once its pullup is on
        xfer(1, 8'h28, 32'h20);
        xfer(1, 8'h18, 32'h20);
        xfer(1, 8'h34, 32'h20);
        wt(8);
        chk({29'h0, vec}, 1);
        xfer(1, 8'h14, 32'h20);
        // rise on 0, 3 and 17, fall on 10 and 17, line 4 left off
        xfer(1, 8'h28, 32'h20009);
        xfer(1, 8'h2C, 32'h20401);
        xfer(1, 8'h18, 32'h20408);
        pad(18'h00438);
        rdchk(8'h14, 32'h8);
        chk({29'h0, vec}, 1);
        pad(18'h00028);
        rdchk(8'h14, 32'h408);
        chk({29'h0, vec}, 3);
        xfer(1, 8'h14, 0);
        rdchk(8'h14, 32'h408);
        xfer(1, 8'h14, 32'h8);
        pad(18'h20028);
        rdchk(8'h14, 32'h20400);
        chk({29'h0, vec}, 6);
        xfer(1, 8'h14, 32'h20000);
        pad(18'h00028);
        rdchk(8'h14, 32'h20400);
        xfer(1, 8'h1C, 32'h400);
        wt(3);
        chk({31'h0, wake}, 1);
        xfer(1, 8'h1C, 0);
        xfer(1, 8'h18, 0);
        wt(3);
        chk({28'h0, wake, vec}, 0);
        // periodic line counts rising edges only
        xfer(1, 8'h14, 32'h3FFFF);
        pad(18'h00029);
        xfer(1, 8'h14, 32'h1);
        pad(18'h00028);
        rdchk(8'h14, 32'h0);
        @(posedge pclk);
        onchip <= 2'b01;
        wt(8);
        chk({31'h0, wake}, 1);
        xfer(1, 8'h14, 32'hC0000);
        rdchk(8'h14, 32'h40000);
        @(posedge pclk);
        onchip <= 2'b00;
        // each destination code, with overrun holding the request
        for (i = 0; i < 4; i++)
        begin
            xfer(1, 8'h08, 32'h04000000 | (i << 29));
            npad(1);
            rdchk(8'h00, 32'h80000000);
            chk({nmi, crit, mchk}, 3'b100 >> i);
            npad(0);
            npad(1);
            rdchk(8'h00, 32'hC0000000);
            xfer(1, 8'h00, 32'h80000000);
            rdchk(8'h00, 32'h40000000);
            chk({nmi, crit, mchk}, 3'b100 >> i);
            xfer(1, 8'h00, 32'h40000000);
            wt(3);
            chk({nmi, crit, mchk}, 0);
            npad(0);
            chk({31'h0, mlock}, 1);
        end
        // nmi filter set in the write that arms the nmi, then ncr locked so a later clear is ignored
        xfer(1, 8'h08, 0);
        xfer(1, 8'h08, 32'h15000000);
        wt(1);
        chk({31'h0, nfe}, 1);
        npad(1);
        chk({30'h0, wake, nmi}, 3);
        xfer(1, 8'h00, 32'hC0000000);
        xfer(1, 8'h08, 32'h84000000);
        xfer(1, 8'h08, 0);
        rdchk(8'h08, 32'h84000000);
        wrap_up();
    end
endmodule // wku_tb_top

`default_nettype wire
